//--- rtl/sdl_link.sv
// Single-pin debug link: autobaud serial, error breaks and debug-mode control.
// Notes on behaviour
// - One shared pin, driven only low; external pull-up gives high.
// - Half-duplex: never transmit while receiving.
// - Frame is low start, eight data bits LSB first, high stop.
// - Measure eight low bit times of 80h to set the bit period.
// - Stay silent after reset until host data has trained the link.
// - Bit period from 4 up to 512 system clocks.
// - Low for nine or more bit times is a break; retrain.
// - Flag low stop bit as framing error; flag transmit collision.
// - On any error abort, drive 4096-cycle break, reset autobaud.
// - Host break leaves control register and debug mode unchanged.
// - Link held in reset during break until pin returns high.
// - Debug mode stops fetch, exits halt, refreshes watchdog.
// - Enter debug on control write, enabled breakpoint, or pin low at reset.
// - Leave debug on bit cleared, power-on, brown-out or reset pin.
// - Pin low in stop mode requests system reset, leaving debug.
// - Opcode 00h with breakpoints on stops CPU; otherwise no-op.
// - Loop mode repeats breakpoint while interrupts and DMA run.
// - Status shows the CPU looping on a breakpoint.
// - Clearing loop bit makes next breakpoint set debug mode.
// - Commands stay disabled while looping on a breakpoint.
// - Debug bit is control bit 7; read protect forbids clearing it by a control write.
`timescale 1ns/1ps
`default_nettype none
module sdl_link #(
  parameter int DEPTH = sdl_pkg::BUF_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic debug_serial_pin_i,
  output logic debug_serial_pin_o,
  output logic debug_serial_pin_oe_n_o,
  output logic [sdl_pkg::DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic [sdl_pkg::DATA_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic err_break_o,
  output logic err_frame_o,
  output logic err_coll_o,
  input wire logic ctl_wr_i,
  input wire logic [7:0] ctl_wdata_i,
  output logic [7:0] debug_control_register_o,
  output logic [7:0] debug_status_register_o,
  input wire logic read_protect_option_i,
  input wire logic por_rst_i,
  input wire logic bor_rst_i,
  input wire logic ext_rst_n_i,
  input wire logic stop_mode_i,
  input wire logic cpu_decode_i,
  input wire logic [7:0] cpu_opcode_i,
  input wire logic dbg_exec_i,
  output logic cpu_fetch_stop_o,
  output logic halt_exit_o,
  output logic wdt_refresh_o,
  output logic brk_nop_o,
  output logic brk_loop_o,
  output logic cmd_enable_o,
  output logic sys_reset_req_o
);
  import sdl_pkg::*;

  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two of at least two");
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic pin_s1_q, pin_q, erst_s1_q, erst_n_q;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_s1_q <= 1'h1;
      pin_q <= 1'h1;
      erst_s1_q <= 1'h1;
      erst_n_q <= 1'h1;
    end else begin
      pin_s1_q <= debug_serial_pin_i;
      pin_q <= pin_s1_q;
      erst_s1_q <= ext_rst_n_i;
      erst_n_q <= erst_s1_q;
    end
  end

  // ----------------------------------------
  // Shared link signals
  // ----------------------------------------
  sdl_rx_e rx_q;
  logic [CNT_W-1:0] tim_q, low_q, tx_tim_q, bit_m1, half_m1, thr;
  logic [DIV_W-1:0] bit_q, div;
  logic [3:0] nbit_q, tx_n_q;
  logic [DATA_W-1:0] sh_q;
  logic [FRAME_BITS-1:0] tx_sh_q;
  logic trained_q, tx_on_q, drive, host_brk, ferr, coll, err, tx_start;
  logic fifo_v;
  logic [DATA_W-1:0] fifo_d;

  assign bit_m1 = {3'h0, bit_q - 10'h001};
  assign half_m1 = {4'h0, bit_q[DIV_W-1:1]} - 13'h0001;
  assign div = tim_q[CNT_W-1:3];
  assign thr = trained_q ? ({bit_q, 3'h0} + {3'h0, bit_q}) : CNT_W'(UNTR_THR);
  assign drive = (rx_q == RX_BRK) || (tx_on_q && !tx_sh_q[0]);
  assign debug_serial_pin_o = 1'h0;
  assign debug_serial_pin_oe_n_o = !drive;
  assign host_brk = (low_q >= thr) && (rx_q != RX_BRK) && (rx_q != RX_HOLD);
  assign ferr = (rx_q == RX_STOP) && (tim_q == bit_m1) && !pin_q;
  assign coll = tx_on_q && tx_sh_q[0] && (tx_tim_q == bit_m1) && !pin_q;
  assign err = host_brk || ferr || coll;

  // Length of the current low level on the pin, ignoring our own drive.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || pin_q || drive) begin
      low_q <= '0;
    end else if (low_q != {CNT_W{1'h1}}) begin
      low_q <= low_q + 13'h0001;
    end
  end

  // ----------------------------------------
  // Receiver, autobaud and error break
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    rx_valid_o <= 1'h0;
    if (sys_rst_i) begin
      rx_q <= RX_UNTR;
      tim_q <= '0;
      nbit_q <= '0;
      sh_q <= '0;
      rx_data_o <= '0;
      trained_q <= 1'h0;
      bit_q <= DIV_W'(MAX_DIV);
    end else if (err) begin
      rx_q <= RX_BRK;
      tim_q <= '0;
      trained_q <= 1'h0;
    end else begin
      case (rx_q)
        RX_UNTR: begin
          tim_q <= '0;
          if (!pin_q) begin
            rx_q <= RX_AB;
            tim_q <= 13'h0001;
          end
        end
        RX_AB: begin
          if (pin_q) begin
            rx_q <= RX_UNTR;
            if (div >= DIV_W'(MIN_DIV) && div <= DIV_W'(MAX_DIV)) begin
              bit_q <= div;
              trained_q <= 1'h1;
              tim_q <= {4'h0, div[DIV_W-1:1]};
              nbit_q <= 4'h7;
              sh_q <= '0;
              rx_q <= RX_DATA;
            end
          end else begin
            tim_q <= tim_q + 13'h0001;
          end
        end
        RX_IDLE: begin
          tim_q <= '0;
          if (!pin_q && !tx_on_q) begin
            rx_q <= RX_START;
          end
        end
        RX_START: begin
          tim_q <= tim_q + 13'h0001;
          if (tim_q == half_m1) begin
            tim_q <= '0;
            nbit_q <= '0;
            rx_q <= pin_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          tim_q <= tim_q + 13'h0001;
          if (tim_q == bit_m1) begin
            tim_q <= '0;
            sh_q <= {pin_q, sh_q[DATA_W-1:1]};
            nbit_q <= nbit_q + 4'h1;
            if (nbit_q == 4'h7) begin
              rx_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          tim_q <= tim_q + 13'h0001;
          if (tim_q == bit_m1) begin
            rx_data_o <= sh_q;
            rx_valid_o <= 1'h1;
            rx_q <= RX_IDLE;
          end
        end
        RX_BRK: begin
          tim_q <= tim_q + 13'h0001;
          if (tim_q == CNT_W'(BREAK_CYC - 1)) begin
            rx_q <= RX_HOLD;
          end
        end
        RX_HOLD: begin
          if (pin_q) begin
            rx_q <= RX_UNTR;
          end
        end
        default: rx_q <= RX_UNTR;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      err_break_o <= 1'h0;
      err_frame_o <= 1'h0;
      err_coll_o <= 1'h0;
    end else begin
      err_break_o <= host_brk;
      err_frame_o <= ferr;
      err_coll_o <= coll;
    end
  end

  a_frame_err: assert property (ferr |=> err_frame_o && rx_q == RX_BRK) else $error("framing error lost");
  a_break_drive: assert property (rx_q == RX_BRK |-> !debug_serial_pin_oe_n_o) else $error("break not driven");
  a_break_end: assert property (rx_q == RX_BRK && tim_q == CNT_W'(BREAK_CYC - 1) |=> rx_q == RX_HOLD)
    else $error("break length");
  a_hold_pin: assert property (rx_q == RX_HOLD && !pin_q |=> rx_q == RX_HOLD) else $error("left hold early");
  a_train_set: assert property (rx_q == RX_AB && pin_q && div >= DIV_W'(MIN_DIV)
    && div <= DIV_W'(MAX_DIV) |=> trained_q && bit_q == $past(div)) else $error("autobaud not set");
  c_trained: cover property (rx_q == RX_AB ##1 trained_q);
  c_rx_word: cover property (rx_valid_o);
  c_break: cover property (rx_q == RX_BRK ##1 rx_q == RX_BRK);

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  logic push;
  assign tx_ready_o = (cnt_q != (PW+1)'(DEPTH));
  assign fifo_v = (cnt_q != '0);
  assign fifo_d = mem_q[rp_q];
  assign push = tx_valid_i && tx_ready_o;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || err) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= tx_data_i;
        wp_q <= wp_q + 1'h1;
      end
      if (tx_start) begin
        rp_q <= rp_q + 1'h1;
      end
      if (push && !tx_start) begin
        cnt_q <= cnt_q + 1'h1;
      end else if (!push && tx_start) begin
        cnt_q <= cnt_q - 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_start = trained_q && (rx_q == RX_IDLE) && pin_q && !tx_on_q && fifo_v;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || err) begin
      tx_on_q <= 1'h0;
      tx_sh_q <= {FRAME_BITS{1'h1}};
      tx_n_q <= '0;
      tx_tim_q <= '0;
    end else if (tx_start) begin
      tx_on_q <= 1'h1;
      tx_sh_q <= {1'h1, fifo_d, 1'h0};
      tx_n_q <= '0;
      tx_tim_q <= '0;
    end else if (tx_on_q) begin
      tx_tim_q <= tx_tim_q + 13'h0001;
      if (tx_tim_q == bit_m1) begin
        tx_tim_q <= '0;
        tx_sh_q <= {1'h1, tx_sh_q[FRAME_BITS-1:1]};
        tx_n_q <= tx_n_q + 4'h1;
        if (tx_n_q == 4'(FRAME_BITS - 1)) begin
          tx_on_q <= 1'h0;
        end
      end
    end
  end

  a_no_tx_untr: assert property (!trained_q |-> !tx_on_q) else $error("sent before training");
  a_half_duplex: assert property (tx_on_q |-> rx_q == RX_IDLE) else $error("send while receiving");
  a_coll_abort: assert property (coll |=> !tx_on_q && err_coll_o) else $error("collision not aborted");

  // ----------------------------------------
  // Debug mode control
  // ----------------------------------------
  logic [7:0] ctl_q, ctl_d;
  logic idle_q, brk_hit, leave, wake, strap;
  logic [1:0] rel_q;
  assign brk_hit = cpu_decode_i && (cpu_opcode_i == BRK_OPCODE) && ctl_q[CTL_BRKEN_BIT];
  assign wake = stop_mode_i && !pin_q && !drive;
  assign leave = por_rst_i || bor_rst_i || !erst_n_q || wake;
  assign strap = (rel_q == 2'(STRAP_DLY)) && !pin_q;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rel_q <= '0;
    end else if (rel_q != 2'h3) begin
      rel_q <= rel_q + 2'h1;
    end
  end

  always_comb begin
    ctl_d = ctl_q;
    if (ctl_wr_i) begin
      ctl_d = ctl_wdata_i;
      if (read_protect_option_i && ctl_q[CTL_DBG_BIT]) begin
        ctl_d[CTL_DBG_BIT] = 1'h1;
      end
    end
    if ((brk_hit && !ctl_q[CTL_LOOP_BIT]) || strap) begin
      ctl_d[CTL_DBG_BIT] = 1'h1;
    end
    if (leave) begin
      ctl_d[CTL_DBG_BIT] = 1'h0;
    end
  end

  // The link error path never touches this register.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctl_q <= CTL_RST;
      idle_q <= 1'h0;
      sys_reset_req_o <= 1'h0;
    end else begin
      ctl_q <= ctl_d;
      sys_reset_req_o <= wake;
      if (leave || ctl_d[CTL_DBG_BIT]) begin
        idle_q <= 1'h0;
      end else if (brk_hit) begin
        idle_q <= ctl_q[CTL_LOOP_BIT];
      end
    end
  end

  assign debug_control_register_o = ctl_q;
  always_comb begin
    debug_status_register_o = 8'h00;
    debug_status_register_o[STAT_DBG_BIT] = ctl_q[CTL_DBG_BIT];
    debug_status_register_o[STAT_IDLE_BIT] = idle_q;
    debug_status_register_o[STAT_TRAIN_BIT] = trained_q;
  end
  assign cpu_fetch_stop_o = ctl_q[CTL_DBG_BIT] && !dbg_exec_i;
  assign halt_exit_o = ctl_q[CTL_DBG_BIT];
  assign wdt_refresh_o = ctl_q[CTL_DBG_BIT];
  assign brk_nop_o = cpu_decode_i && (cpu_opcode_i == BRK_OPCODE) && !ctl_q[CTL_BRKEN_BIT];
  assign brk_loop_o = idle_q;
  assign cmd_enable_o = ctl_q[CTL_DBG_BIT] && !idle_q;

  a_brk_stop: assert property (brk_hit && !ctl_q[CTL_LOOP_BIT] && !leave |=> ctl_q[CTL_DBG_BIT] && !idle_q)
    else $error("breakpoint did not stop");
  a_brk_loop: assert property (brk_hit && ctl_q[CTL_LOOP_BIT] && !leave && !ctl_d[CTL_DBG_BIT] |=> brk_loop_o)
    else $error("breakpoint loop not flagged");
  a_rp_keep: assert property (read_protect_option_i && ctl_q[CTL_DBG_BIT] && !leave |=> ctl_q[CTL_DBG_BIT])
    else $error("debug bit cleared under protect");
  a_reset_leave: assert property (leave |=> !ctl_q[CTL_DBG_BIT]) else $error("debug mode kept on reset");
  a_cmd_gate: assert property (idle_q |-> !cmd_enable_o) else $error("commands open while looping");
  c_loop_exit: cover property (idle_q ##1 !ctl_q[CTL_LOOP_BIT] ##[1:20] ctl_q[CTL_DBG_BIT]);
endmodule // sdl_link
`default_nettype wire

//--- rtl/sdl_pkg.sv
// Shared constants and state encodings of the single-pin debug link.
package sdl_pkg;
  // ----------------------------------------
  // Timing and sizing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W = 13;
  localparam int DIV_W = 10;
  localparam int MIN_DIV = 4;
  localparam int MAX_DIV = 512;
  localparam int AB_LOW_BITS = 8;
  localparam int BRK_BITS = 9;
  localparam int UNTR_THR = BRK_BITS * MAX_DIV;
  localparam int BREAK_CYC = 4096;
  localparam int FRAME_BITS = 10;
  localparam int STRAP_DLY = 2;
  localparam logic [7:0] BRK_OPCODE = 8'h00;
  // ----------------------------------------
  // Control and status fields
  // ----------------------------------------
  localparam int CTL_DBG_BIT = 7;
  localparam int CTL_BRKEN_BIT = 6;
  localparam int CTL_LOOP_BIT = 5;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam int STAT_DBG_BIT = 7;
  localparam int STAT_IDLE_BIT = 5;
  localparam int STAT_TRAIN_BIT = 0;
  // ----------------------------------------
  // Receiver states
  // ----------------------------------------
  typedef enum logic [2:0] {
    RX_UNTR = 3'h0,
    RX_AB = 3'h1,
    RX_IDLE = 3'h2,
    RX_START = 3'h3,
    RX_DATA = 3'h4,
    RX_STOP = 3'h5,
    RX_BRK = 3'h6,
    RX_HOLD = 3'h7
  } sdl_rx_e;
endpackage

//--- sim/sdl_host.sv
// Host debugger model that drives and listens on the shared open-drain pin.
`timescale 1ns/1ps
`default_nettype none
module sdl_host (
  input wire logic core_clk_i,
  input wire logic pin_i,
  output logic host_oe_n_o
);
  import sdl_pkg::*;
  // ------
  // Pin driving and sampling
  // ------
  initial host_oe_n_o = 1'b1;
  task automatic hold_low(input int n);
    @(posedge core_clk_i);
    host_oe_n_o <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    host_oe_n_o <= 1'b1;
  endtask
  task automatic send(input int div, input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    @(posedge core_clk_i);
    for (int i = 0; i < FRAME_BITS; i++) begin
      host_oe_n_o <= f[i];
      repeat (div) @(posedge core_clk_i);
    end
    host_oe_n_o <= 1'b1;
  endtask
  task automatic recv(input int div, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    ok = 1'b0;
    while ((pin_i !== 1'b0 || !host_oe_n_o) && n < 20000) begin
      @(negedge core_clk_i);
      n++;
    end
    repeat (div / 2) @(negedge core_clk_i);
    ok = (pin_i === 1'b0);
    for (int i = 0; i < DATA_W; i++) begin
      repeat (div) @(negedge core_clk_i);
      d[i] = pin_i;
    end
    repeat (div) @(negedge core_clk_i);
    ok = ok & (pin_i === 1'b1);
  endtask
endmodule // sdl_host
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench of the single-pin debug link against a host model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdl_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pin, pin_do, dut_oe_n, host_oe_n, rx_valid, tx_ready, e_brk, e_frm, e_col;
  logic tx_valid = 1'b0, ctl_wr = 1'b0, rp = 1'b0, por = 1'b0, bor = 1'b0, ext_rst_n = 1'b1;
  logic stop_mode = 1'b0, decode = 1'b0, dbg_exec = 1'b0;
  logic [7:0] tx_data = 8'h00, ctl_wdata = 8'h00, opcode = 8'h00;
  logic [7:0] rx_data, ctl, stat, rx_last;
  logic fetch_stop, halt_exit, wdt_ref, brk_nop, brk_loop, cmd_en, srr;
  int mismatches = 0, checks_done = 0, n_brk = 0, n_frm = 0, n_col = 0, n_srr = 0;
  int rx_cnt = 0, run = 0, last_run = 0;
  always #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
  assign pin = !dut_oe_n ? pin_do : (!host_oe_n ? 1'b0 : 1'b1);
  sdl_host host (.core_clk_i(core_clk_i), .pin_i(pin), .host_oe_n_o(host_oe_n));
  sdl_link #(.DEPTH(BUF_DEPTH)) DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .debug_serial_pin_i(pin), .debug_serial_pin_o(pin_do), .debug_serial_pin_oe_n_o(dut_oe_n),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .err_break_o(e_brk), .err_frame_o(e_frm), .err_coll_o(e_col),
    .ctl_wr_i(ctl_wr), .ctl_wdata_i(ctl_wdata), .debug_control_register_o(ctl),
    .debug_status_register_o(stat), .read_protect_option_i(rp), .por_rst_i(por), .bor_rst_i(bor),
    .ext_rst_n_i(ext_rst_n), .stop_mode_i(stop_mode), .cpu_decode_i(decode), .cpu_opcode_i(opcode),
    .dbg_exec_i(dbg_exec), .cpu_fetch_stop_o(fetch_stop), .halt_exit_o(halt_exit),
    .wdt_refresh_o(wdt_ref), .brk_nop_o(brk_nop), .brk_loop_o(brk_loop), .cmd_enable_o(cmd_en),
    .sys_reset_req_o(srr));
  always @(posedge core_clk_i) begin
    if (rx_valid) begin
      rx_last <= rx_data;
      rx_cnt <= rx_cnt + 1;
    end
    n_brk <= n_brk + int'(e_brk);
    n_frm <= n_frm + int'(e_frm);
    n_col <= n_col + int'(e_col);
    n_srr <= n_srr + int'(srr);
    run <= dut_oe_n ? 0 : run + 1;
    if (dut_oe_n && run != 0) begin
      last_run <= run;
    end
  end
  // ------
  // Tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic rst();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    wait_n(16);
  endtask
  task automatic wr_ctl(input logic [7:0] v);
    @(posedge core_clk_i);
    ctl_wr <= 1'b1;
    ctl_wdata <= v;
    @(posedge core_clk_i);
    ctl_wr <= 1'b0;
    wait_n(1);
  endtask
  task automatic breakpoint_instruction(output logic nop);
    @(posedge core_clk_i);
    decode <= 1'b1;
    opcode <= BRK_OPCODE;
    @(negedge core_clk_i);
    nop = brk_nop;
    @(posedge core_clk_i);
    decode <= 1'b0;
    wait_n(2);
  endtask
  task automatic push(input logic [7:0] d);
    logic r;
    @(posedge core_clk_i);
    tx_valid <= 1'b1;
    tx_data <= d;
    do begin
      @(negedge core_clk_i);
      r = tx_ready;
      @(posedge core_clk_i);
    end while (!r);
    tx_valid <= 1'b0;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk_i);
    mismatches++;
    stop_test();
  end
  // ------
  // Tests
  // ------
  initial begin
    logic [7:0] b0, b1;
    logic ok0, ok1, nop;
    int n;
    rst();
    check({dut_oe_n, tx_ready}, 2'b11);
    check({ctl, stat}, {CTL_RST, 8'h00});
    check(pin_do, 1'b0);
    breakpoint_instruction(nop);
    check({nop, ctl[7]}, 2'b10);
    wr_ctl(8'h40);
    breakpoint_instruction(nop);
    check({nop, ctl[7]}, 2'b01);
    check({fetch_stop, halt_exit, wdt_ref}, 3'b111);
    @(posedge core_clk_i);
    dbg_exec <= 1'b1;
    wait_n(1);
    check(fetch_stop, 1'b0);
    @(posedge core_clk_i);
    dbg_exec <= 1'b0;
    wr_ctl(8'h40);
    check(ctl[7], 1'b0);
    wr_ctl(8'h60);
    breakpoint_instruction(nop);
    check({brk_loop, stat[STAT_IDLE_BIT], ctl[7], cmd_en}, 4'b1100);
    wr_ctl(8'h40);
    breakpoint_instruction(nop);
    check({brk_loop, ctl[7], cmd_en}, 3'b011);
    @(posedge core_clk_i);
    rp <= 1'b1;
    wr_ctl(8'h00);
    check(ctl[7], 1'b1);
    @(posedge core_clk_i);
    rp <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      wr_ctl(8'h80);
      @(posedge core_clk_i);
      por <= (k == 0);
      bor <= (k == 1);
      ext_rst_n <= (k != 2);
      repeat (4) @(posedge core_clk_i);
      por <= 1'b0;
      bor <= 1'b0;
      ext_rst_n <= 1'b1;
      wait_n(4);
      check(ctl[7], 1'b0);
    end
    wr_ctl(8'h80);
    @(posedge core_clk_i);
    stop_mode <= 1'b1;
    host.hold_low(6);
    wait_n(4);
    check({n_srr != 0, ctl[7], stat[STAT_TRAIN_BIT]}, 3'b100);
    @(posedge core_clk_i);
    stop_mode <= 1'b0;
    fork
      host.hold_low(14);
      rst();
    join
    check(ctl[7], 1'b1);
    rst();
    $display("test control done");
    push(8'h3C);
    push(8'hC3);
    wait_n(20);
    check({tx_ready, dut_oe_n}, 2'b01);
    fork
      host.send(8, 8'h80, 1'b1);
      begin
        host.recv(8, b0, ok0);
        host.recv(8, b1, ok1);
      end
    join
    check({ok0, b0, ok1, b1}, 18'h279C3);
    check(stat[STAT_TRAIN_BIT], 1'b1);
    wait_n(8);
    n = rx_cnt;
    host.send(8, 8'hA5, 1'b1);
    host.send(8, 8'h5A, 1'b1);
    wait_n(8);
    check({rx_last, 8'(rx_cnt - n)}, 16'h5A02);
    $display("test link done");
    host.send(8, 8'h55, 1'b0);
    wait_n(4300);
    check({16'(n_frm), 16'(last_run)}, {16'h0001, 16'(BREAK_CYC)});
    check(stat[STAT_TRAIN_BIT], 1'b0);
    wr_ctl(8'h80);
    host.send(8, 8'h80, 1'b1);
    host.hold_low(96);
    wait_n(4300);
    check({16'(n_brk), ctl, stat[STAT_DBG_BIT]}, {16'h0001, 8'h80, 1'b1});
    check({stat[STAT_TRAIN_BIT], 16'(last_run)}, {1'b0, 16'(BREAK_CYC)});
    host.send(8, 8'h80, 1'b1);
    wait_n(30);
    push(8'hFF);
    fork
      host.recv(8, b0, ok0);
      begin
        wait_n(30);
        host.hold_low(16);
      end
    join
    wait_n(4300);
    check({16'(n_col), 16'(last_run)}, {16'h0001, 16'(BREAK_CYC)});
    $display("test errors done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
